// ===== inc/link_cap2_pkg.sv
// register indices, field layout and reset values of the link capability register bank
package link_cap2_pkg;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] IDX_FW_REV     = 8'h6C;
  localparam logic [7:0] IDX_LINK_STATE = 8'hB2;
  localparam logic [7:0] IDX_CPL_SUPP   = 8'hC4;
  localparam logic [7:0] IDX_CPL_CTRL   = 8'hC8;
  localparam logic [7:0] IDX_DEV_STS_RS = 8'hCA;
  localparam logic [7:0] IDX_LINK_CAP_RS = 8'hCC;
  localparam logic [7:0] IDX_COMPL_CTRL = 8'hD0;
  localparam logic [7:0] IDX_DEEMPH     = 8'hD2;
  localparam logic [7:0] IDX_PHY_TUNE0  = 8'hDC;
  localparam logic [7:0] IDX_PHY_TUNE1  = 8'hE0;
  localparam int         ADDR_LSB       = 2;
  localparam int         ADDR_MSB       = 9;

  // link state report
  localparam int SPEED_LSB   = 0;
  localparam int WIDTH_LSB   = 4;
  localparam int SLOT_CLK_B  = 12;
  localparam int DL_ACTIVE_B = 13;
  localparam logic [3:0] SPEED_2G5 = 4'h1;
  localparam logic [3:0] SPEED_5G0 = 4'h2;

  // completion and latency support / control
  localparam int CPL_RANGE_LSB  = 0;
  localparam int CPL_DIS_SUPP_B = 4;
  localparam int LTR_SUPP_B     = 11;
  localparam int CPL_VALUE_LSB  = 0;
  localparam int CPL_DIS_B      = 4;
  localparam int LTR_EN_B       = 10;
  localparam logic [3:0] CPL_RANGES    = 4'h0;
  localparam logic [3:0] CPL_VALUE_RST = 4'h0;
  localparam int CPL_DEFAULT_MIN_US = 50;
  localparam int CPL_DEFAULT_MAX_MS = 50;

  // compliance control
  localparam int TGT_SPEED_LSB = 0;
  localparam int ENTER_COMPL_B = 4;
  localparam int AUTO_HOLD_B   = 5;
  localparam int TX_MARGIN_LSB = 7;
  localparam int MOD_COMPL_B   = 10;
  localparam int COMPL_SKP_B   = 11;
  localparam int COMPL_DEEMPH_B = 12;
  localparam logic [3:0] TGT_SPEED_RST = 4'h2;

  // de-emphasis report: 1 = -3.5 dB, 0 = -6 dB
  localparam logic DEEMPH_RST = 1'b1;
  localparam int   FW_LOW_LSB = 8;
endpackage : link_cap2_pkg

// ===== logic/pcie_link_cap2_config_regs.sv
// link status, completion timeout, latency report and compliance registers on AHB-Lite
`timescale 1ns/1ps
// Operation
// R1: link speed field reads 0001b for 2.5 GT/s, 0010b for 5.0 GT/s.
// R2: six-bit negotiated lane count at link status bits 9:4, read-only.
// R3: link status bit 12 reads one: platform reference clock used.
// R4: link status bit 13 is high only while data link layer is active.
// R5: completion timeout ranges field reads zero, range not programmable.
// R6: capability bit 4 reads one: timeout disable supported.
// R7: capability bit 11 reads one: latency tolerance reporting supported.
// R8: four-bit timeout value, reset zero, zero selects 50 us to 50 ms.
// R9: control bit 4 set stops timeout detection; resets to zero.
// R10: latency messages sent only while control bit 10 is one.
// R11: sticky target speed field, default 0010b for 5.0 GT/s.
// R12: enter-compliance bit plus hot reset forces compliance at target speed.
// R13: sticky bit 5 blocks autonomous speed changes except lowering for reliability.
// R14: sticky three-bit transmit margin selects transmitter output level.
// R15: sticky bit 10 selects modified compliance pattern in polling compliance.
// R16: sticky bit 11 inserts skip ordered sets between compliance patterns.
// R17: bit 12 de-emphasis applies only when compliance entered through enter bit.
// R18: at 5 GT/s bit 0 reports de-emphasis, 1 is -3.5 dB; resets one.
// R19: reserved bits and registers read zero, writes ignored.
// R20: sticky fields survive hot and warm reset, cleared by power-on only.
module pcie_link_cap2_config_regs #(
  parameter logic [7:0]  FW_REV_LOW    = 8'h01, // arbitrary
  parameter logic [7:0]  FW_REV_HIGH   = 8'h00, // arbitrary
  parameter logic [31:0] PHY_TUNE0_RST = 32'h0000_0000,
  parameter logic [31:0] PHY_TUNE1_RST = 32'h0000_0000,
  parameter bit          PHY_TUNE1_RW  = 1'b1
) (
  // clock and resets
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        PWR_ON_RST_N_IN,
  // ahb-lite slave
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic [31:0]      HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  // link state from training logic
  input  wire logic [3:0]  LINK_SPEED_IN,
  input  wire logic [5:0]  LINK_WIDTH_IN,
  input  wire logic        DL_ACTIVE_IN,
  input  wire logic        DEEMPH_LEVEL_IN,
  input  wire logic        HOT_RESET_IN,
  input  wire logic        POLL_COMPLIANCE_IN,
  // controls to completion and latency logic
  output logic [3:0]       CPL_TIMEOUT_VALUE_OUT,
  output logic             CPL_TIMEOUT_DETECT_EN_OUT,
  output logic             LTR_SEND_EN_OUT,
  // controls to training logic and transmitter
  output logic             FORCE_COMPLIANCE_OUT,
  output logic [3:0]       COMPLIANCE_SPEED_OUT,
  output logic             AUTO_SPEED_UP_BLOCK_OUT,
  output logic [2:0]       TX_MARGIN_OUT,
  output logic             MOD_PATTERN_SEL_OUT,
  output logic             SKP_INSERT_OUT,
  output logic             COMPL_DEEMPH_APPLY_OUT,
  output logic             COMPL_DEEMPH_SEL_OUT,
  output logic [31:0]      PHY_TUNE0_OUT,
  output logic [31:0]      PHY_TUNE1_OUT
);

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_RWAIT = 2'b01,
    BUS_RDONE = 2'b10
  } bus_state_t;

  bus_state_t  bus_state;
  logic        wr_pend;
  logic [7:0]  wr_idx;
  logic [7:0]  rd_idx;
  logic        addr_ok;
  logic        req;
  logic [3:0]  link_speed;
  logic [5:0]  link_width;
  logic        dl_active;
  logic [3:0]  cpl_value;
  logic        cpl_disable;
  logic        ltr_en;
  logic [3:0]  tgt_speed;
  logic        enter_compl;
  logic        auto_hold;
  logic [2:0]  tx_margin;
  logic        mod_compl;
  logic        compl_skp;
  logic        compl_deemph;
  logic        deemph_level;
  logic        poll_prev;
  logic        entry_by_bit;
  logic [31:0] phy_tune0;
  logic [31:0] phy_tune1;

  // word at a register index; unmapped and reserved parts read zero
  function automatic logic [31:0] read_word(input logic [7:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (idx)
      link_cap2_pkg::IDX_FW_REV: begin
        w[link_cap2_pkg::FW_LOW_LSB +: 16] = {FW_REV_HIGH, FW_REV_LOW};
      end
      link_cap2_pkg::IDX_LINK_STATE: begin
        w[link_cap2_pkg::SPEED_LSB +: 4] = link_speed;                       // R1
        w[link_cap2_pkg::WIDTH_LSB +: 6] = link_width;                       // R2
        w[link_cap2_pkg::SLOT_CLK_B]     = 1'b1;                             // R3
        w[link_cap2_pkg::DL_ACTIVE_B]    = dl_active;                        // R4
      end
      link_cap2_pkg::IDX_CPL_SUPP: begin
        w[link_cap2_pkg::CPL_RANGE_LSB +: 4] = link_cap2_pkg::CPL_RANGES;   // R5
        w[link_cap2_pkg::CPL_DIS_SUPP_B]     = 1'b1;                         // R6
        w[link_cap2_pkg::LTR_SUPP_B]         = 1'b1;                         // R7
      end
      link_cap2_pkg::IDX_CPL_CTRL: begin
        w[link_cap2_pkg::CPL_VALUE_LSB +: 4] = cpl_value;
        w[link_cap2_pkg::CPL_DIS_B]          = cpl_disable;
        w[link_cap2_pkg::LTR_EN_B]           = ltr_en;
      end
      link_cap2_pkg::IDX_COMPL_CTRL: begin
        w[link_cap2_pkg::TGT_SPEED_LSB +: 4] = tgt_speed;
        w[link_cap2_pkg::ENTER_COMPL_B]      = enter_compl;
        w[link_cap2_pkg::AUTO_HOLD_B]        = auto_hold;
        w[link_cap2_pkg::TX_MARGIN_LSB +: 3] = tx_margin;
        w[link_cap2_pkg::MOD_COMPL_B]        = mod_compl;
        w[link_cap2_pkg::COMPL_SKP_B]        = compl_skp;
        w[link_cap2_pkg::COMPL_DEEMPH_B]     = compl_deemph;
      end
      link_cap2_pkg::IDX_DEEMPH: begin
        w[0] = deemph_level;                                                 // R18
      end
      link_cap2_pkg::IDX_PHY_TUNE0: begin
        w = phy_tune0;
      end
      link_cap2_pkg::IDX_PHY_TUNE1: begin
        w = PHY_TUNE1_RW ? phy_tune1 : 32'h0000_0000;
      end
      default: begin
        w = 32'h0000_0000;                                                   // R19
      end
    endcase
    return w;
  endfunction : read_word

  assign addr_ok = (HADDR_IN[31:link_cap2_pkg::ADDR_MSB+1] == '0);
  assign req     = HSEL_IN && HREADY_IN && HTRANS_IN[1];

  // bus slave: writes without wait, reads with one wait state
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      bus_state     <= BUS_IDLE;
      wr_pend       <= 1'b0;
      wr_idx        <= 8'h00;
      rd_idx        <= 8'h00;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
      HRDATA_OUT    <= 32'h0000_0000;
    end else begin
      HRESP_OUT <= 1'b0;
      wr_pend   <= 1'b0;
      case (bus_state)
        BUS_IDLE: begin
          if (req && HWRITE_IN) begin
            wr_pend <= addr_ok;
            wr_idx  <= HADDR_IN[link_cap2_pkg::ADDR_MSB:link_cap2_pkg::ADDR_LSB];
          end else if (req) begin
            rd_idx        <= addr_ok ?
                             HADDR_IN[link_cap2_pkg::ADDR_MSB:link_cap2_pkg::ADDR_LSB] : 8'h00;
            HREADYOUT_OUT <= 1'b0;
            bus_state     <= BUS_RWAIT;
          end
        end
        BUS_RWAIT: begin
          HRDATA_OUT    <= read_word(rd_idx);
          HREADYOUT_OUT <= 1'b1;
          bus_state     <= BUS_RDONE;
        end
        BUS_RDONE: begin
          HRDATA_OUT <= 32'h0000_0000;
          bus_state  <= BUS_IDLE;
          if (req && HWRITE_IN) begin
            wr_pend <= addr_ok;
            wr_idx  <= HADDR_IN[link_cap2_pkg::ADDR_MSB:link_cap2_pkg::ADDR_LSB];
          end else if (req) begin
            rd_idx        <= addr_ok ?
                             HADDR_IN[link_cap2_pkg::ADDR_MSB:link_cap2_pkg::ADDR_LSB] : 8'h00;
            HREADYOUT_OUT <= 1'b0;
            bus_state     <= BUS_RWAIT;
          end
        end
        default: begin
          bus_state     <= BUS_IDLE;
          HREADYOUT_OUT <= 1'b1;
        end
      endcase
    end
  end

  // live link state captured for reads
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      link_speed <= link_cap2_pkg::SPEED_2G5;
      link_width <= 6'h01;
      dl_active  <= 1'b0;
    end else begin
      link_speed <= LINK_SPEED_IN;                                           // R1
      link_width <= LINK_WIDTH_IN;                                           // R2
      dl_active  <= DL_ACTIVE_IN;                                            // R4
    end
  end

  // de-emphasis only tracked while running at 5 GT/s
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      deemph_level <= link_cap2_pkg::DEEMPH_RST;                             // R18
    end else if (LINK_SPEED_IN == link_cap2_pkg::SPEED_5G0) begin
      deemph_level <= DEEMPH_LEVEL_IN;                                       // R18
    end
  end

  // non-sticky completion and latency controls
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cpl_value   <= link_cap2_pkg::CPL_VALUE_RST;                           // R8
      cpl_disable <= 1'b0;                                                   // R9
      ltr_en      <= 1'b0;                                                   // R10
    end else if (wr_pend && wr_idx == link_cap2_pkg::IDX_CPL_CTRL) begin
      cpl_value   <= HWDATA_IN[link_cap2_pkg::CPL_VALUE_LSB +: 4];           // R8
      cpl_disable <= HWDATA_IN[link_cap2_pkg::CPL_DIS_B];                    // R9
      ltr_en      <= HWDATA_IN[link_cap2_pkg::LTR_EN_B];                     // R10
    end
  end

  // sticky fields: power-on reset only
  always_ff @(posedge CLK_SYS_IN or negedge PWR_ON_RST_N_IN) begin
    if (!PWR_ON_RST_N_IN) begin
      tgt_speed    <= link_cap2_pkg::TGT_SPEED_RST;                          // R20
      enter_compl  <= 1'b0;
      auto_hold    <= 1'b0;
      tx_margin    <= 3'h0;
      mod_compl    <= 1'b0;
      compl_skp    <= 1'b0;
      compl_deemph <= 1'b0;
    end else if (wr_pend && wr_idx == link_cap2_pkg::IDX_COMPL_CTRL) begin
      tgt_speed    <= HWDATA_IN[link_cap2_pkg::TGT_SPEED_LSB +: 4];          // R11
      enter_compl  <= HWDATA_IN[link_cap2_pkg::ENTER_COMPL_B];               // R12
      auto_hold    <= HWDATA_IN[link_cap2_pkg::AUTO_HOLD_B];                 // R13
      tx_margin    <= HWDATA_IN[link_cap2_pkg::TX_MARGIN_LSB +: 3];          // R14
      mod_compl    <= HWDATA_IN[link_cap2_pkg::MOD_COMPL_B];                 // R15
      compl_skp    <= HWDATA_IN[link_cap2_pkg::COMPL_SKP_B];                 // R16
      compl_deemph <= HWDATA_IN[link_cap2_pkg::COMPL_DEEMPH_B];              // R17
    end
  end

  // phy tuning words
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      phy_tune0 <= PHY_TUNE0_RST;
      phy_tune1 <= PHY_TUNE1_RST;
    end else if (wr_pend) begin
      if (wr_idx == link_cap2_pkg::IDX_PHY_TUNE0) begin
        phy_tune0 <= HWDATA_IN;
      end
      if (wr_idx == link_cap2_pkg::IDX_PHY_TUNE1 && PHY_TUNE1_RW) begin
        phy_tune1 <= HWDATA_IN;
      end
    end
  end

  // compliance entry bookkeeping
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      poll_prev            <= 1'b0;
      entry_by_bit         <= 1'b0;
      FORCE_COMPLIANCE_OUT <= 1'b0;
    end else begin
      poll_prev <= POLL_COMPLIANCE_IN;
      if (POLL_COMPLIANCE_IN && !poll_prev) begin
        entry_by_bit <= enter_compl;                                         // R17
      end else if (!POLL_COMPLIANCE_IN) begin
        entry_by_bit <= 1'b0;
      end
      if (HOT_RESET_IN && enter_compl) begin
        FORCE_COMPLIANCE_OUT <= 1'b1;                                        // R12
      end else if (!enter_compl) begin
        FORCE_COMPLIANCE_OUT <= 1'b0;
      end
    end
  end

  // control outputs, all registered
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      CPL_TIMEOUT_VALUE_OUT     <= link_cap2_pkg::CPL_VALUE_RST;
      CPL_TIMEOUT_DETECT_EN_OUT <= 1'b1;
      LTR_SEND_EN_OUT           <= 1'b0;
      COMPLIANCE_SPEED_OUT      <= link_cap2_pkg::TGT_SPEED_RST;
      AUTO_SPEED_UP_BLOCK_OUT   <= 1'b0;
      TX_MARGIN_OUT             <= 3'h0;
      MOD_PATTERN_SEL_OUT       <= 1'b0;
      SKP_INSERT_OUT            <= 1'b0;
      COMPL_DEEMPH_APPLY_OUT    <= 1'b0;
      COMPL_DEEMPH_SEL_OUT      <= 1'b0;
      PHY_TUNE0_OUT             <= PHY_TUNE0_RST;
      PHY_TUNE1_OUT             <= PHY_TUNE1_RST;
    end else begin
      CPL_TIMEOUT_VALUE_OUT     <= cpl_value;                                // R8
      CPL_TIMEOUT_DETECT_EN_OUT <= !cpl_disable;                             // R9
      LTR_SEND_EN_OUT           <= ltr_en;                                   // R10
      COMPLIANCE_SPEED_OUT      <= tgt_speed;                                // R11
      AUTO_SPEED_UP_BLOCK_OUT   <= auto_hold;                                // R13
      TX_MARGIN_OUT             <= tx_margin;                                // R14
      MOD_PATTERN_SEL_OUT       <= POLL_COMPLIANCE_IN && mod_compl;          // R15
      SKP_INSERT_OUT            <= POLL_COMPLIANCE_IN && compl_skp;          // R16
      COMPL_DEEMPH_APPLY_OUT    <= POLL_COMPLIANCE_IN && poll_prev && entry_by_bit; // R17
      COMPL_DEEMPH_SEL_OUT      <= compl_deemph;                             // R17
      PHY_TUNE0_OUT             <= phy_tune0;
      PHY_TUNE1_OUT             <= phy_tune1;
    end
  end

  AST_LTR_GATE: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // R10
    LTR_SEND_EN_OUT |-> $past(ltr_en))
    else $error("latency reporting enabled without control bit");
  AST_CPL_DETECT: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // R9
    (wr_pend && wr_idx == link_cap2_pkg::IDX_CPL_CTRL &&
     HWDATA_IN[link_cap2_pkg::CPL_DIS_B]) |=> ##1
    !CPL_TIMEOUT_DETECT_EN_OUT)
    else $error("timeout detection not stopped after disable write");
  AST_MOD_PATTERN: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // R15
    MOD_PATTERN_SEL_OUT |-> $past(POLL_COMPLIANCE_IN) && $past(mod_compl))
    else $error("modified pattern outside polling compliance");
  AST_SKP_INSERT: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // R16
    (POLL_COMPLIANCE_IN && compl_skp) |=> SKP_INSERT_OUT)
    else $error("skip sets not inserted during compliance");
  AST_DEEMPH_ENTRY: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // R17
    (POLL_COMPLIANCE_IN && !poll_prev && !enter_compl) |=> ##1 !COMPL_DEEMPH_APPLY_OUT)
    else $error("compliance de-emphasis applied without enter bit");
  AST_FORCE_COMPL: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // R12
    (HOT_RESET_IN && enter_compl) |=> FORCE_COMPLIANCE_OUT)
    else $error("hot reset with enter bit did not force compliance");
  AST_DEEMPH_HOLD: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // R18
    ($past(LINK_SPEED_IN) != link_cap2_pkg::SPEED_5G0) |-> $stable(deemph_level))
    else $error("de-emphasis report changed away from 5 GT/s");
  AST_READ_TIMING: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // one wait state on reads
    (bus_state == BUS_IDLE && req && !HWRITE_IN) |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT)
    else $error("read did not complete after one wait state");
  AST_LINK_STATUS: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // R4
    (bus_state == BUS_RWAIT && rd_idx == link_cap2_pkg::IDX_LINK_STATE) |=>
    (HRDATA_OUT[13] == $past(dl_active)) && HRDATA_OUT[12] && HRDATA_OUT[15:14] == 2'b00)
    else $error("link status read wrong");

endmodule : pcie_link_cap2_config_regs

// ===== testbench/link_train_model.sv
// behavioural model of the training logic and link partner feeding the register bank
`timescale 1ns/1ps
module link_train_model (
  // clock
  input  wire logic       clk_in,
  // live link state
  output logic [3:0]      speed_out,
  output logic [5:0]      width_out,
  output logic            dl_active_out,
  output logic            deemph_out,
  output logic            hot_reset_out,
  output logic            poll_compl_out
);
  initial begin
    speed_out      = 4'h1;
    width_out      = 6'h01;
    dl_active_out  = 1'b0;
    deemph_out     = 1'b1;
    hot_reset_out  = 1'b0;
    poll_compl_out = 1'b0;
  end
  task automatic set_link(input logic [3:0] s, input logic [5:0] w, input logic a, input logic d);
    @(posedge clk_in);
    speed_out     <= s;
    width_out     <= w;
    dl_active_out <= a;
    deemph_out    <= d;
  endtask : set_link
  // the link sees a hot reset for one clock cycle
  task automatic hot_reset_pulse();
    @(posedge clk_in);
    hot_reset_out <= 1'b1;
    @(posedge clk_in);
    hot_reset_out <= 1'b0;
  endtask : hot_reset_pulse
  task automatic set_poll(input logic v);
    @(posedge clk_in);
    poll_compl_out <= v;
  endtask : set_poll
endmodule : link_train_model

// ===== testbench/pcie_link_cap2_config_regs_bench.sv
// self-checking bench for the link capability register bank over ahb-lite
`timescale 1ns/1ps
module pcie_link_cap2_config_regs_bench;
  logic        clk       = 1'b0;
  logic        rst_n     = 1'b0;
  logic        pwr_rst_n = 1'b0;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0000_0000;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [31:0] hwdata    = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [3:0]  speed;
  logic [5:0]  width;
  logic        dl_act;
  logic        deemph;
  logic        hot_rst;
  logic        poll;
  logic [3:0]  cto_val;
  logic        cto_en;
  logic        ltr_en;
  logic        force_c;
  logic [3:0]  c_speed;
  logic        hold;
  logic [2:0]  margin;
  logic        mod_sel;
  logic        skp;
  logic        d_apply;
  logic        d_sel;
  logic [31:0] phy0;
  logic [31:0] phy1;
  int          fail_count = 0;
  int          n_compared = 0;

  always #4 clk = ~clk;

  link_train_model u_link (.clk_in(clk), .speed_out(speed), .width_out(width),
    .dl_active_out(dl_act), .deemph_out(deemph), .hot_reset_out(hot_rst), .poll_compl_out(poll));

  pcie_link_cap2_config_regs u_dut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n),
    .PWR_ON_RST_N_IN(pwr_rst_n),
    .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
    .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
    .HRESP_OUT(hresp), .LINK_SPEED_IN(speed), .LINK_WIDTH_IN(width), .DL_ACTIVE_IN(dl_act),
    .DEEMPH_LEVEL_IN(deemph), .HOT_RESET_IN(hot_rst), .POLL_COMPLIANCE_IN(poll),
    .CPL_TIMEOUT_VALUE_OUT(cto_val), .CPL_TIMEOUT_DETECT_EN_OUT(cto_en), .LTR_SEND_EN_OUT(ltr_en),
    .FORCE_COMPLIANCE_OUT(force_c), .COMPLIANCE_SPEED_OUT(c_speed), .AUTO_SPEED_UP_BLOCK_OUT(hold),
    .TX_MARGIN_OUT(margin), .MOD_PATTERN_SEL_OUT(mod_sel), .SKP_INSERT_OUT(skp),
    .COMPL_DEEMPH_APPLY_OUT(d_apply), .COMPL_DEEMPH_SEL_OUT(d_sel), .PHY_TUNE0_OUT(phy0),
    .PHY_TUNE1_OUT(phy1));

  task automatic end_sim();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  // wait for hready at a rising edge, bounded
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      fail_count++;
      end_sim();
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask : wr

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0000_0000, rd);
    chk(rd, exp);
  endtask : rdchk

  // let the register and its control output land
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic pulse_reset(input logic pwr);
    @(posedge clk);
    rst_n     <= 1'b0;
    pwr_rst_n <= pwr ? 1'b0 : 1'b1;
    repeat (3) @(posedge clk);
    rst_n     <= 1'b1;
    pwr_rst_n <= 1'b1;
    @(posedge clk);
  endtask : pulse_reset

  initial begin
    repeat (3) @(posedge clk);
    rst_n     <= 1'b1;
    pwr_rst_n <= 1'b1;
    @(posedge clk);
    rdchk(32'h0000_02C8, 32'h0000_1011);
    rdchk(32'h0000_0348, 32'h0000_0001);
    rdchk(32'h0000_0310, 32'h0000_0810);
    rdchk(32'h0000_01B0, 32'h0000_0100);
    u_link.set_link(4'h2, 6'h04, 1'b1, 1'b0);
    settle();
    rdchk(32'h0000_02C8, 32'h0000_3042);
    rdchk(32'h0000_0348, 32'h0000_0000);
    u_link.set_link(4'h2, 6'h04, 1'b0, 1'b1);
    settle();
    rdchk(32'h0000_02C8, 32'h0000_1042);
    rdchk(32'h0000_0348, 32'h0000_0001);
    // timeout and latency controls
    rdchk(32'h0000_0320, 32'h0000_0000);
    chk({30'h0, cto_en, ltr_en}, 32'h0000_0002);
    wr(32'h0000_0320, 32'hFFFF_FFFF);
    rdchk(32'h0000_0320, 32'h0000_041F);
    settle();
    chk({26'h0, cto_val, cto_en, ltr_en}, 32'h0000_003D);
    wr(32'h0000_0320, 32'h0000_0000);
    settle();
    chk({26'h0, cto_val, cto_en, ltr_en}, 32'h0000_0002);
    // compliance controls
    rdchk(32'h0000_0340, 32'h0000_0002);
    wr(32'h0000_0340, 32'hFFFF_FFFF);
    rdchk(32'h0000_0340, 32'h0000_1FBF);
    settle();
    chk({22'h0, c_speed, hold, margin, d_sel, force_c}, 32'h0000_03FE);
    u_link.hot_reset_pulse();
    settle();
    chk({31'h0, force_c}, 32'h0000_0001);
    u_link.set_poll(1'b1);
    repeat (3) @(posedge clk);
    #1;
    chk({29'h0, mod_sel, skp, d_apply}, 32'h0000_0007);
    u_link.set_poll(1'b0);
    // reserved, unmapped and out-of-range places, then both phy tuning words
    wr(32'h0000_0328, 32'hFFFF_FFFF);
    rdchk(32'h0000_0328, 32'h0000_0000);
    wr(32'h0000_0330, 32'hFFFF_FFFF);
    rdchk(32'h0000_0330, 32'h0000_0000);
    rdchk(32'h0000_0004, 32'h0000_0000);
    wr(32'h0000_1320, 32'hFFFF_FFFF);
    rdchk(32'h0000_0320, 32'h0000_0000);
    wr(32'h0000_0370, 32'hA5A5_5A5A);
    rdchk(32'h0000_0370, 32'hA5A5_5A5A);
    chk(phy0, 32'hA5A5_5A5A);
    wr(32'h0000_0380, 32'h1234_5678);
    settle();
    chk(phy1, 32'h1234_5678);
    // sticky fields across link reset, cleared at power-on
    wr(32'h0000_0320, 32'h0000_0005);
    pulse_reset(1'b0);
    rdchk(32'h0000_0340, 32'h0000_1FBF);
    rdchk(32'h0000_0320, 32'h0000_0000);
    pulse_reset(1'b1);
    rdchk(32'h0000_0340, 32'h0000_0002);
    settle();
    chk({28'h0, c_speed}, 32'h0000_0002);
    // compliance entered without the enter bit: no de-emphasis apply
    u_link.set_poll(1'b1);
    repeat (3) @(posedge clk);
    #1;
    chk({29'h0, mod_sel, skp, d_apply}, 32'h0000_0000);
    u_link.set_poll(1'b0);
    settle();
    end_sim();
  end
endmodule : pcie_link_cap2_config_regs_bench
